// ===== logic/mdr_dma_top.sv
// 32-channel DMA engine: request capture, arbitration, control table
// walk and item moves for stop, basic, auto and ping-pong modes.
// Assumes an Avalon-MM master for registers and an Avalon-style slave
// memory on the same clock; peripheral requests are asynchronous levels.
//
// Operation
// [R1] Burst request wins over a single request when both are asserted.
// [R2] A lone single request moves one item, then the channel waits.
// [R3] A burst moves the lesser of arbitration size and items remaining.
// [R4] Burst-only channels ignore single requests entirely.
// [R5] Software aligns the control table to a 1024-byte boundary.
// [R6] Primary structure at base plus 16 per channel; alternates from 0x200.
// [R7] Structure words: source end, destination end, control word, unused.
// [R8] End pointers are inclusive; current address is derived from them.
// [R9] Count and mode are written back; completion leaves zero and stop.
// [R10] End pointer words are never written by the engine.
// [R11] Software rewrites the control word before each new transfer.
// [R12] Enable-set starts a channel; enable-clear disables it.
// [R13] A finished transfer clears the channel enable; ping-pong keeps it set.
// [R14] Stop mode moves nothing and clears the enable.
// [R15] Basic mode continues only while items remain and request holds.
// [R16] Auto mode runs to the last item once a request is taken.
// [R17] Ping-pong switches to the other structure after each completion.
// [R18] Each ping-pong switch raises the channel completion pulse.
// [R19] Control word carries sizes, increments, arbitration, count, flag, mode.
// [R20] Alternate halves and the unused word are only touched when needed.
// [R21] Serial port raises burst at four entries, single on fifo space.
// [R22] Channel 0 highest; high-priority channels rank above the rest.
// [R23] Arbitration size 1 to 1024 items, re-arbitrating afterwards.
// [R24] Each channel has its own completion output.
// [R25] Mode encoding: 0 stop, 1 basic, 2 auto, 3 ping-pong.
//
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module mdr_dma_top
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [5:0] av_address_i,
  input wire logic av_read_i,
  input wire logic av_write_i,
  input wire logic [31:0] av_writedata_i,
  input wire logic [3:0] av_byteenable_i,
  output logic [31:0] av_readdata_o,
  output logic av_waitrequest_o,
  input wire logic [31:0] single_req_i,
  input wire logic [31:0] burst_req_i,
  output logic [31:0] mem_address_o,
  output logic mem_read_o,
  output logic mem_write_o,
  output logic [31:0] mem_writedata_o,
  output logic [3:0] mem_byteenable_o,
  input wire logic [31:0] mem_readdata_i,
  input wire logic mem_waitrequest_i,
  output logic [31:0] done_o,
  output logic busy_o
);

  // ****************************************
  // State
  // ****************************************
  mdr_pkg::mdr_state_type state_reg, state_next;
  logic [4:0] ch_reg, ch_next;
  logic burst_reg, burst_next;
  logic [10:0] rem_reg, rem_next;
  logic [10:0] left_reg, left_next;
  logic [31:0] src_end_reg, dst_end_reg, ctl_reg, data_reg;
  logic [21:0] tbl_base_reg;
  logic [31:0] enable_reg, useburst_reg, prio_reg, swreq_reg;
  logic [31:0] auto_reg, alt_reg, done_reg;
  logic [31:0] sreq1_reg, sreq2_reg, breq1_reg, breq2_reg;
  logic [31:0] mem_addr_reg, mem_wdata_reg, av_rdata_reg;
  logic [3:0] mem_be_reg;
  logic mem_read_reg, mem_write_reg, wait_reg, busy_reg;
  logic hw_clr_f, tgl_f, auto_set_f, auto_clr_f, take_f, done_f;

  // ****************************************
  // Register bus decode
  // ****************************************
  wire [31:0] wmask = {{8{av_byteenable_i[3]}}, {8{av_byteenable_i[2]}},
                       {8{av_byteenable_i[1]}}, {8{av_byteenable_i[0]}}};
  wire [31:0] wd = av_writedata_i & wmask;
  // The write lands on the edge where the master sees waitrequest low
  wire wr_fire = av_write_i & ~wait_reg;
  wire wr_base = wr_fire & (av_address_i == mdr_pkg::REG_TABLE_BASE);
  wire [31:0] en_set = (wr_fire & (av_address_i == mdr_pkg::REG_ENABLE_SET))
                       ? wd : 32'h0000_0000;
  wire [31:0] en_clr =
    (wr_fire & (av_address_i == mdr_pkg::REG_ENABLE_CLEAR)) ? wd : 32'h0;
  wire [31:0] ub_set = (wr_fire & (av_address_i == mdr_pkg::REG_BURST_SET))
                       ? wd : 32'h0000_0000;
  wire [31:0] ub_clr = (wr_fire & (av_address_i == mdr_pkg::REG_BURST_CLEAR))
                       ? wd : 32'h0000_0000;
  wire [31:0] pr_set = (wr_fire & (av_address_i == mdr_pkg::REG_PRIO_SET))
                       ? wd : 32'h0000_0000;
  wire [31:0] pr_clr = (wr_fire & (av_address_i == mdr_pkg::REG_PRIO_CLEAR))
                       ? wd : 32'h0000_0000;
  wire [31:0] sw_trig = (wr_fire & (av_address_i == mdr_pkg::REG_SW_REQUEST))
                        ? wd : 32'h0000_0000;
  wire [31:0] status_word = {19'h0, ch_reg, 7'h0, busy_reg};
  wire [31:0] rd_mux =
    (av_address_i == mdr_pkg::REG_TABLE_BASE) ?
      {tbl_base_reg, 10'h000} :
    ((av_address_i == mdr_pkg::REG_ENABLE_SET) |
     (av_address_i == mdr_pkg::REG_ENABLE_CLEAR)) ? enable_reg :
    ((av_address_i == mdr_pkg::REG_BURST_SET) |
     (av_address_i == mdr_pkg::REG_BURST_CLEAR)) ? useburst_reg :
    ((av_address_i == mdr_pkg::REG_PRIO_SET) |
     (av_address_i == mdr_pkg::REG_PRIO_CLEAR)) ? prio_reg :
    (av_address_i == mdr_pkg::REG_SW_REQUEST) ? swreq_reg :
    (av_address_i == mdr_pkg::REG_ALT_STATUS) ? alt_reg :
    (av_address_i == mdr_pkg::REG_ENGINE_STATUS) ? status_word :
    32'h0000_0000;

  // ****************************************
  // Requests and arbitration
  // ****************************************
  wire [31:0] ch_onehot = 32'h0000_0001 << ch_reg;
  wire [31:0] single_ok = sreq2_reg & ~useburst_reg; // [R4]
  wire [31:0] pend = enable_reg &
                     (auto_reg | swreq_reg | breq2_reg | single_ok); // [R12]
  wire [31:0] hi_pend = pend & prio_reg;
  wire [31:0] tier = (|hi_pend) ? hi_pend : pend; // [R22]
  wire any_pend = |pend;
  logic [4:0] win_idx;

  // Lowest channel number of the chosen tier wins
  always_comb
  begin
    win_idx = 5'h00;
    for (int i = mdr_pkg::CH_NUM - 1; i >= 0; i--)
    begin
      if (tier[i])
      begin
        win_idx = 5'(i); // [R22]
      end
    end
  end

  wire [31:0] win_onehot = 32'h0000_0001 << win_idx;

  // ****************************************
  // Control word decode and addresses
  // ****************************************
  wire [2:0] mode = ctl_reg[mdr_pkg::MODE_LSB +: mdr_pkg::MODE_W]; // [R19]
  wire ctl_only_burst = ctl_reg[mdr_pkg::ONLY_BURST_BIT];
  wire [10:0] cnt = ctl_reg[mdr_pkg::CNT_LSB +: mdr_pkg::CNT_W];
  wire [3:0] arb_raw = ctl_reg[mdr_pkg::ARB_LSB +: mdr_pkg::ARB_W];
  wire [1:0] s_size = ctl_reg[mdr_pkg::SSIZE_LSB +: 2];
  wire [1:0] s_inc = ctl_reg[mdr_pkg::SINC_LSB +: 2];
  wire [1:0] d_size = ctl_reg[mdr_pkg::DSIZE_LSB +: 2];
  wire [1:0] d_inc = ctl_reg[mdr_pkg::DINC_LSB +: 2];
  wire mode_auto = (mode == mdr_pkg::MODE_AUTO); // [R25]
  wire mode_pp = (mode == mdr_pkg::MODE_PINGPONG);
  wire mode_basic = (mode == mdr_pkg::MODE_BASIC);
  // Encodings above ping-pong are not supported and act as stop
  wire mode_runs = mode_basic | mode_auto | mode_pp; // [R14]
  wire [3:0] arb_log = (arb_raw > mdr_pkg::ARB_LOG_MAX) ?
                       mdr_pkg::ARB_LOG_MAX : arb_raw;
  wire [10:0] arb_size = 11'h001 << arb_log; // [R23]
  wire [10:0] burst_len = (arb_size < cnt) ? arb_size : cnt; // [R3]

  // Current address = end minus the items still to go after this one
  wire [10:0] rem_m1 = rem_reg - 11'h001;
  wire [12:0] s_ofs = {2'h0, rem_m1} << s_inc;
  wire [12:0] d_ofs = {2'h0, rem_m1} << d_inc;
  wire [31:0] src_addr = (s_inc == mdr_pkg::INC_NONE) ? src_end_reg :
                         src_end_reg - {19'h0, s_ofs}; // [R8]
  wire [31:0] dst_addr = (d_inc == mdr_pkg::INC_NONE) ? dst_end_reg :
                         dst_end_reg - {19'h0, d_ofs}; // [R8]
  wire alt_cur = |(alt_reg & ch_onehot); // [R20]
  wire [31:0] struct_base = {tbl_base_reg, alt_cur, ch_reg,
                             mdr_pkg::STRUCT_LOW}; // [R6]
  wire [3:0] s_be = (s_size == mdr_pkg::SIZE_BYTE) ?
                    (mdr_pkg::BE_BYTE << src_addr[1:0]) :
                    (s_size == mdr_pkg::SIZE_HALF) ?
                    (mdr_pkg::BE_HALF << src_addr[1:0]) : mdr_pkg::BE_WORD;
  wire [3:0] d_be = (d_size == mdr_pkg::SIZE_BYTE) ?
                    (mdr_pkg::BE_BYTE << dst_addr[1:0]) :
                    (d_size == mdr_pkg::SIZE_HALF) ?
                    (mdr_pkg::BE_HALF << dst_addr[1:0]) : mdr_pkg::BE_WORD;
  wire [31:0] lane_data = (data_reg >> {src_addr[1:0], 3'h0})
                          << {dst_addr[1:0], 3'h0};
  wire [2:0] mode_wb = (rem_reg == 11'h000) ? mdr_pkg::MODE_STOP : mode;
  wire [31:0] ctl_wb = {ctl_reg[31:15], rem_reg, ctl_only_burst,
                        mode_wb}; // [R9]

  // ****************************************
  // Memory master
  // ****************************************
  wire mem_act = mem_read_reg | mem_write_reg;
  wire acc_done = mem_act & ~mem_waitrequest_i;
  wire st_rd = (state_reg == mdr_pkg::ST_SRC) |
               (state_reg == mdr_pkg::ST_DST) |
               (state_reg == mdr_pkg::ST_CTL) |
               (state_reg == mdr_pkg::ST_RDATA);
  wire st_wr = (state_reg == mdr_pkg::ST_WDATA) |
               (state_reg == mdr_pkg::ST_WCTL);
  // Only the control word is ever written back in the table
  wire [31:0] addr_mux =
    (state_reg == mdr_pkg::ST_SRC) ? (struct_base |
      {28'h0, mdr_pkg::SRC_END_OFS}) :
    (state_reg == mdr_pkg::ST_DST) ? (struct_base |
      {28'h0, mdr_pkg::DST_END_OFS}) :
    (state_reg == mdr_pkg::ST_RDATA) ? src_addr :
    (state_reg == mdr_pkg::ST_WDATA) ? dst_addr :
    (struct_base | {28'h0, mdr_pkg::CTL_WORD_OFS}); // [R7] [R10]
  wire [31:0] wdata_mux = (state_reg == mdr_pkg::ST_WDATA) ? lane_data :
                          ctl_wb;
  wire [3:0] be_mux = (state_reg == mdr_pkg::ST_RDATA) ? s_be :
                      (state_reg == mdr_pkg::ST_WDATA) ? d_be :
                      mdr_pkg::BE_WORD;
  // A new access starts one cycle after the previous one completes
  wire mem_read_next = mem_act ? (mem_read_reg & ~acc_done) : st_rd;
  wire mem_write_next = mem_act ? (mem_write_reg & ~acc_done) : st_wr;
  wire keep_req = mem_act;

  // ****************************************
  // Transfer sequencer
  // ****************************************
  wire req_holds = burst_reg & |(breq2_reg & ch_onehot);
  wire auto_cur = |(auto_reg & ch_onehot);

  always_comb
  begin
    state_next = state_reg;
    ch_next = ch_reg;
    burst_next = burst_reg;
    rem_next = rem_reg;
    left_next = left_reg;
    hw_clr_f = 1'b0;
    tgl_f = 1'b0;
    auto_set_f = 1'b0;
    auto_clr_f = 1'b0;
    take_f = 1'b0;
    done_f = 1'b0;
    unique case (state_reg)
      mdr_pkg::ST_IDLE:
      begin
        if (any_pend)
        begin
          ch_next = win_idx;
          burst_next = |(breq2_reg & win_onehot); // [R1]
          take_f = 1'b1;
          state_next = mdr_pkg::ST_SRC;
        end
      end
      mdr_pkg::ST_SRC:
      begin
        if (acc_done)
        begin
          state_next = mdr_pkg::ST_DST;
        end
      end
      mdr_pkg::ST_DST:
      begin
        if (acc_done)
        begin
          state_next = mdr_pkg::ST_CTL;
        end
      end
      mdr_pkg::ST_CTL:
      begin
        if (acc_done)
        begin
          state_next = mdr_pkg::ST_PLAN;
        end
      end
      mdr_pkg::ST_PLAN:
      begin
        if (!mode_runs)
        begin
          hw_clr_f = 1'b1; // [R14]
          auto_clr_f = 1'b1;
          state_next = mdr_pkg::ST_IDLE;
        end
        else if (ctl_only_burst & ~burst_reg & ~auto_cur)
        begin
          state_next = mdr_pkg::ST_IDLE; // [R4]
        end
        else if (cnt == 11'h000)
        begin
          rem_next = 11'h000;
          state_next = mdr_pkg::ST_WCTL;
        end
        else
        begin
          rem_next = cnt;
          left_next = (burst_reg | mode_auto) ? burst_len : 11'h001; // [R2]
          auto_set_f = mode_auto; // [R16]
          state_next = mdr_pkg::ST_RDATA;
        end
      end
      mdr_pkg::ST_RDATA:
      begin
        if (acc_done)
        begin
          state_next = mdr_pkg::ST_WDATA;
        end
      end
      mdr_pkg::ST_WDATA:
      begin
        if (acc_done)
        begin
          rem_next = rem_m1;
          left_next = left_reg - 11'h001;
          if ((rem_reg > 11'h001) & (left_reg > 11'h001) &
              (mode_auto | req_holds)) // [R15] [R16]
          begin
            state_next = mdr_pkg::ST_RDATA;
          end
          else
          begin
            state_next = mdr_pkg::ST_WCTL; // [R23]
          end
        end
      end
      mdr_pkg::ST_WCTL:
      begin
        if (acc_done)
        begin
          if (rem_reg == 11'h000)
          begin
            done_f = 1'b1; // [R24] [R18]
            tgl_f = mode_pp; // [R17]
            hw_clr_f = ~mode_pp; // [R13]
            auto_clr_f = 1'b1;
          end
          state_next = mdr_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // ****************************************
  // Per-channel flag updates
  // ****************************************
  // Software set wins over a clear arriving in the same cycle
  wire [31:0] hw_clr = hw_clr_f ? ch_onehot : 32'h0000_0000;
  wire [31:0] enable_next = (enable_reg & ~hw_clr & ~en_clr) | en_set;
  wire [31:0] alt_next = (alt_reg ^ (tgl_f ? ch_onehot : 32'h0)) & ~en_set;
  wire [31:0] auto_next = ((auto_reg | (auto_set_f ? ch_onehot : 32'h0)) &
                           ~(auto_clr_f ? ch_onehot : 32'h0) & ~en_clr) |
                          32'h0000_0000;
  wire [31:0] swreq_next = (swreq_reg & ~(take_f ? win_onehot : 32'h0)) |
                           sw_trig;
  wire [31:0] done_next = done_f ? ch_onehot : 32'h0000_0000;

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sreq1_reg <= 32'h0000_0000;
      sreq2_reg <= 32'h0000_0000;
      breq1_reg <= 32'h0000_0000;
      breq2_reg <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      sreq1_reg <= single_req_i;
      sreq2_reg <= sreq1_reg;
      breq1_reg <= burst_req_i;
      breq2_reg <= breq1_reg;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tbl_base_reg <= 22'h000000;
      enable_reg <= 32'h0000_0000;
      useburst_reg <= 32'h0000_0000;
      prio_reg <= 32'h0000_0000;
      swreq_reg <= 32'h0000_0000;
      auto_reg <= 32'h0000_0000;
      alt_reg <= 32'h0000_0000;
      done_reg <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      if (wr_base)
      begin
        // Low bits are dropped, so the table is always 1 KB aligned
        tbl_base_reg <= wd[31:mdr_pkg::TBL_ALIGN_W]; // [R5]
      end
      enable_reg <= enable_next; // [R12]
      useburst_reg <= (useburst_reg & ~ub_clr) | ub_set;
      prio_reg <= (prio_reg & ~pr_clr) | pr_set;
      swreq_reg <= swreq_next;
      auto_reg <= auto_next;
      alt_reg <= alt_next;
      done_reg <= done_next;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_reg <= mdr_pkg::ST_IDLE;
      ch_reg <= 5'h00;
      burst_reg <= 1'b0;
      rem_reg <= 11'h000;
      left_reg <= 11'h000;
      busy_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      state_reg <= state_next;
      ch_reg <= ch_next;
      burst_reg <= burst_next;
      rem_reg <= rem_next;
      left_reg <= left_next;
      busy_reg <= (state_next != mdr_pkg::ST_IDLE);
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      src_end_reg <= 32'h0000_0000;
      dst_end_reg <= 32'h0000_0000;
      ctl_reg <= 32'h0000_0000;
      data_reg <= 32'h0000_0000;
    end
    else if (ce_i & acc_done)
    begin
      if (state_reg == mdr_pkg::ST_SRC)
      begin
        src_end_reg <= mem_readdata_i;
      end
      if (state_reg == mdr_pkg::ST_DST)
      begin
        dst_end_reg <= mem_readdata_i;
      end
      if (state_reg == mdr_pkg::ST_CTL)
      begin
        ctl_reg <= mem_readdata_i;
      end
      if (state_reg == mdr_pkg::ST_RDATA)
      begin
        data_reg <= mem_readdata_i;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      mem_read_reg <= 1'b0;
      mem_write_reg <= 1'b0;
      mem_addr_reg <= 32'h0000_0000;
      mem_wdata_reg <= 32'h0000_0000;
      mem_be_reg <= 4'h0;
    end
    else if (ce_i)
    begin
      mem_read_reg <= mem_read_next;
      mem_write_reg <= mem_write_next;
      if (!keep_req)
      begin
        mem_addr_reg <= addr_mux;
        mem_wdata_reg <= wdata_mux;
        mem_be_reg <= be_mux;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wait_reg <= 1'b1;
      av_rdata_reg <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      // One wait cycle per access, then waitrequest drops for one cycle
      wait_reg <= ~((av_read_i | av_write_i) & wait_reg);
      if (av_read_i & wait_reg)
      begin
        av_rdata_reg <= rd_mux;
      end
    end
  end

  assign av_readdata_o = av_rdata_reg;
  assign av_waitrequest_o = wait_reg;
  assign mem_address_o = mem_addr_reg;
  assign mem_read_o = mem_read_reg;
  assign mem_write_o = mem_write_reg;
  assign mem_writedata_o = mem_wdata_reg;
  assign mem_byteenable_o = mem_be_reg;
  assign done_o = done_reg;
  assign busy_o = busy_reg;

endmodule // mdr_dma_top

// ===== logic/mdr_pkg.sv
// Shared constants of the multichannel request-driven DMA engine.
// Assumes a 32-bit system bus with byte addresses and 32 channels.
package mdr_pkg;

  // ****************************************
  // Channels and register map
  // ****************************************
  localparam int CH_NUM = 32;
  localparam int CH_W = 5;
  localparam int AV_ADDR_W = 6;
  localparam logic [5:0] REG_TABLE_BASE = 6'h00;
  localparam logic [5:0] REG_ENABLE_SET = 6'h04;
  localparam logic [5:0] REG_ENABLE_CLEAR = 6'h08;
  localparam logic [5:0] REG_BURST_SET = 6'h0C;
  localparam logic [5:0] REG_BURST_CLEAR = 6'h10;
  localparam logic [5:0] REG_PRIO_SET = 6'h14;
  localparam logic [5:0] REG_PRIO_CLEAR = 6'h18;
  localparam logic [5:0] REG_SW_REQUEST = 6'h1C;
  localparam logic [5:0] REG_ALT_STATUS = 6'h20;
  localparam logic [5:0] REG_ENGINE_STATUS = 6'h24;

  // ****************************************
  // Control table layout
  // ****************************************
  localparam int TBL_ALIGN_W = 10;
  localparam logic [3:0] STRUCT_LOW = 4'h0;
  localparam logic [3:0] SRC_END_OFS = 4'h0;
  localparam logic [3:0] DST_END_OFS = 4'h4;
  localparam logic [3:0] CTL_WORD_OFS = 4'h8;

  // ****************************************
  // Control word fields
  // ****************************************
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 3;
  localparam int ONLY_BURST_BIT = 3;
  localparam int CNT_LSB = 4;
  localparam int CNT_W = 11;
  localparam int ARB_LSB = 15;
  localparam int ARB_W = 4;
  localparam int SSIZE_LSB = 24;
  localparam int SINC_LSB = 26;
  localparam int DSIZE_LSB = 28;
  localparam int DINC_LSB = 30;
  localparam logic [3:0] ARB_LOG_MAX = 4'hA;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] INC_NONE = 2'h3;
  localparam logic [3:0] BE_BYTE = 4'h1;
  localparam logic [3:0] BE_HALF = 4'h3;
  localparam logic [3:0] BE_WORD = 4'hF;

  typedef enum logic [2:0] {
    MODE_STOP = 3'h0,
    MODE_BASIC = 3'h1,
    MODE_AUTO = 3'h2,
    MODE_PINGPONG = 3'h3
  } mdr_mode_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SRC = 3'h1,
    ST_DST = 3'h2,
    ST_CTL = 3'h3,
    ST_PLAN = 3'h4,
    ST_RDATA = 3'h5,
    ST_WDATA = 3'h6,
    ST_WCTL = 3'h7
  } mdr_state_type;

endpackage

// ===== testbench/mdr_dma_assertions.sv
// Port-level checks of the DMA engine top.
// Assumes the bench places the control table at address 0.
`timescale 1ns/1ps
module mdr_dma_assertions
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic av_read_i,
  input wire logic av_write_i,
  input wire logic av_waitrequest_o,
  input wire logic [31:0] mem_address_o,
  input wire logic mem_read_o,
  input wire logic mem_write_o,
  input wire logic [31:0] mem_writedata_o,
  input wire logic mem_waitrequest_i,
  input wire logic [31:0] done_o,
  input wire logic busy_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);
  wire logic acc = mem_read_o | mem_write_o;
  property p_wait_one;
    (av_read_i || av_write_i) && av_waitrequest_o |=> !av_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("register wait not one cycle");
  property p_wait_back;
    !av_waitrequest_o |=> av_waitrequest_o;
  endproperty
  a_wait_back: assert property (p_wait_back)
    else $error("register answer too long");
  property p_mem_hold;
    acc && mem_waitrequest_i |=>
      $stable({mem_read_o, mem_write_o, mem_address_o, mem_writedata_o});
  endproperty
  a_mem_hold: assert property (p_mem_hold)
    else $error("memory request changed while stalled");
  property p_mem_drop;
    acc && !mem_waitrequest_i |=> !acc;
  endproperty
  a_mem_drop: assert property (p_mem_drop)
    else $error("memory strobe not dropped");
  // Only the control word of a structure may ever be written back
  property p_tbl_wr;
    mem_write_o && mem_address_o < 32'h400 |-> mem_address_o[3:0] == 4'h8;
  endproperty
  a_tbl_wr: assert property (p_tbl_wr)
    else $error("table write outside control word");
  property p_done_src;
    |done_o |-> $past(mem_write_o && !mem_waitrequest_i);
  endproperty
  a_done_src: assert property (p_done_src)
    else $error("done without control write");
  property p_done_pulse;
    |done_o |-> $onehot(done_o) ##1 done_o == 32'h0;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done not a single pulse");
  property p_busy;
    acc |-> busy_o;
  endproperty
  a_busy: assert property (p_busy)
    else $error("memory access while idle");
endmodule // mdr_dma_assertions

// ===== testbench/mdr_mem_model.sv
// Word memory on the engine's master port, holding table and buffers.
// Assumes the engine holds each request until waitrequest is seen low.
`timescale 1ns/1ps
module mdr_mem_model
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic slow_i,
  input wire logic [31:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o
);
  // Bench keeps the table at 0, on a 1024-byte boundary
  logic [31:0] mem [0:511];
  logic waited;
  wire logic [8:0] idx = address_i[10:2];
  wire logic req = read_i | write_i;
  assign waitrequest_o = req & slow_i & ~waited;
  // Outside a completed read the bus shows garbage, never a stale word
  assign readdata_o = (read_i & ~waitrequest_o) ? mem[idx] : ~mem[idx];
  always @(posedge core_clk_i or negedge rstn_i)
    if (!rstn_i)
      waited <= 1'b0;
    else if (req & ~waitrequest_o)
    begin
      waited <= 1'b0;
      if (write_i)
        mem[idx] <= writedata_i;
    end
    else if (req)
      waited <= 1'b1;
endmodule // mdr_mem_model

// ===== testbench/tb_top.sv
// Bench for the DMA engine: register tasks, table set up in the model.
// Assumes the memory model keeps its words in array mem.
`timescale 1ns/1ps
module tb_top;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [5:0] av_address_i = 6'h00;
  logic av_read_i = 1'b0;
  logic av_write_i = 1'b0;
  logic slow = 1'b1;
  logic [31:0] av_writedata_i = 32'h0;
  logic [31:0] single_req_i = 32'h0;
  logic [31:0] burst_req_i = 32'h0;
  logic [31:0] av_readdata_o, mem_address_o, mem_writedata_o;
  logic [31:0] mem_readdata_i, done_o, q;
  logic av_waitrequest_o, mem_read_o, mem_write_o;
  logic mem_waitrequest_i, busy_o;
  logic [3:0] mem_byteenable_o;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int dn = 0;
  always #25 core_clk_i = ~core_clk_i;
  mdr_dma_top u_mdr_dma_top (.ce_i(1'b1), .av_byteenable_i(4'hF), .*);
  mdr_mem_model u_mdr_mem_model (.core_clk_i(core_clk_i),
    .rstn_i(rstn_i), .slow_i(slow), .address_i(mem_address_o),
    .read_i(mem_read_o), .write_i(mem_write_o),
    .writedata_i(mem_writedata_o), .readdata_o(mem_readdata_i),
    .waitrequest_o(mem_waitrequest_i));
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (|done_o)
      dn++;
    if (cyc == 20000)
    begin
      err_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One Avalon access; waits for waitrequest low, data left in q
  task automatic av(input logic w, input logic [5:0] a, input int d);
    @(posedge core_clk_i);
    av_address_i <= a;
    av_writedata_i <= d;
    av_write_i <= w;
    av_read_i <= ~w;
    @(posedge core_clk_i);
    while (av_waitrequest_o !== 1'b0)
      @(posedge core_clk_i);
    q = av_readdata_o;
    av_write_i <= 1'b0;
    av_read_i <= 1'b0;
  endtask
  // Auto mode idles one cycle between chunks: wait for four quiet cycles
  task automatic settle();
    int n = 0;
    repeat (8) @(posedge core_clk_i);
    while (n < 4)
    begin
      @(posedge core_clk_i);
      n = (busy_o === 1'b0) ? n + 1 : 0;
    end
  endtask
  // Word items, word increments; sources at 0x400, targets at 0x600
  task automatic setup(input int ch, input logic [2:0] md, input int cnt,
    input logic [3:0] arb);
    for (int i = 0; i < 4; i++)
    begin
      u_mdr_mem_model.mem[256 + i] = 32'hA500 + i;
      u_mdr_mem_model.mem[384 + i] = 32'h0;
    end
    u_mdr_mem_model.mem[ch * 4] = 32'h400 + (cnt - 1) * 4;
    u_mdr_mem_model.mem[ch * 4 + 1] = 32'h600 + (cnt - 1) * 4;
    u_mdr_mem_model.mem[ch * 4 + 2] = {8'hAA, 5'h0, arb, 11'(cnt), 1'b0, md};
  endtask
  task automatic dst(input int moved);
    for (int i = 0; i < 3; i++)
      chk(u_mdr_mem_model.mem[384 + i], i < moved ? 32'hA500 + i : 32'h0);
  endtask
  task automatic ctl(input int ch, input logic [14:0] exp);
    chk({17'h0, u_mdr_mem_model.mem[ch * 4 + 2][14:0]}, {17'h0, exp});
  endtask
  task automatic go(input int ch);
    av(1'b1, mdr_pkg::REG_ENABLE_SET, 1 << ch);
    av(1'b1, mdr_pkg::REG_SW_REQUEST, 1 << ch);
    settle();
  endtask
  task automatic en(input int exp);
    av(1'b0, mdr_pkg::REG_ENABLE_SET, 0);
    chk(q, exp);
  endtask
  initial
  begin
    repeat (3) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    en(0);
    av(1'b0, 6'h3C, 0);
    chk(q, 32'h0);
    av(1'b1, mdr_pkg::REG_TABLE_BASE, 0);
    setup(1, mdr_pkg::MODE_AUTO, 3, 4'h0);
    go(1);
    dst(3);
    ctl(1, 15'h0);
    chk(u_mdr_mem_model.mem[4], 32'h408);
    en(0);
    slow <= 1'b0;
    setup(2, mdr_pkg::MODE_BASIC, 3, 4'h2);
    go(2);
    dst(1);
    ctl(2, {11'h2, 4'h1});
    en(32'h4);
    av(1'b1, mdr_pkg::REG_ENABLE_CLEAR, 32'h4);
    en(0);
    setup(3, mdr_pkg::MODE_STOP, 3, 4'h0);
    go(3);
    dst(0);
    en(0);
    setup(4, mdr_pkg::MODE_BASIC, 3, 4'h2);
    av(1'b1, mdr_pkg::REG_BURST_SET, 32'h10);
    av(1'b1, mdr_pkg::REG_ENABLE_SET, 32'h10);
    single_req_i <= 32'h10;
    settle();
    dst(0);
    burst_req_i <= 32'h10;
    settle();
    dst(3);
    ctl(4, 15'h0);
    setup(5, mdr_pkg::MODE_PINGPONG, 1, 4'h0);
    go(5);
    dst(1);
    av(1'b0, mdr_pkg::REG_ALT_STATUS, 0);
    chk(q, 32'h20);
    en(32'h20);
    chk(dn, 3);
    stop_test();
  end
endmodule // tb_top
bind mdr_dma_top mdr_dma_assertions u_mdr_dma_assertions (.*);
